// file: logic/llm_defines.svh
`ifndef LLM_DEFINES_SVH
`define LLM_DEFINES_SVH

// Register word indices; the byte address is four times the index
`define LLM_IDX_CTRL 8'h16
`define LLM_IDX_UPPER 8'h17
`define LLM_IDX_LOWER 8'h18
`define LLM_IDX_IRQ_STAT 8'h20
`define LLM_IDX_IRQ_MASK 8'h21

// Bus geometry
`define LLM_ADDR_W 10
`define LLM_RESP_OKAY 2'h0
`define LLM_RESP_SLVERR 2'h2

// Reset values and write masks
`define LLM_CTRL_RST 16'h7F00
`define LLM_CTRL_WMASK 16'hFFF7
`define LLM_IRQ_MASK_RST 2'h0

// Field positions in the upper status register
`define LLM_UP_START_LSB 12
`define LLM_UP_STOP_LSB 8
`define LLM_UP_DONE_BIT 4

// Interrupt status bits
`define LLM_IRQ_START 0
`define LLM_IRQ_DONE 1

// Cycle tally
`define LLM_TALLY_W 20
`define LLM_TALLY_MAX 20'hFFFFF

// Divider counter width, enough for divide by 8
`define LLM_DIV_W 3

`endif

// file: logic/llm_pkg.sv
package llm_pkg;

  typedef struct packed {
    logic [7:0] spare_hi;
    logic start_sel;
    logic stop_sel;
    logic [1:0] tick_div;
    logic spare_b3;
    logic tick_src;
    logic enable;
    logic chan;
  } llm_ctrl_t;

  // Comma detections of one channel, one bit per lane or half-word
  typedef struct packed {
    logic [3:0] ls_tx;
    logic [1:0] hs_rx;
    logic [3:0] ls_rx;
    logic [1:0] hs_tx;
  } llm_comma_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_COUNT = 2'b10,
    ST_DONE = 2'b11
  } llm_state_t;

endpackage

// file: logic/llm_tick_gen.sv
`timescale 1ns/1ps
`include "llm_defines.svh"

module llm_tick_gen #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Selection
  input wire logic src_sel_i,
  input wire logic [1:0] div_i,
  input wire logic chan_i,
  // Recovered byte clocks, asynchronous
  input wire logic [CHANNELS-1:0] byte_clk_i,
  // Measurement tick
  output logic tick_o
);

  logic [CHANNELS-1:0] sync_a;
  logic [CHANNELS-1:0] sync_b;
  logic [CHANNELS-1:0] sync_c;
  logic [CHANNELS-1:0] rise;
  logic [`LLM_DIV_W-1:0] cnt;
  logic [`LLM_DIV_W-1:0] mask;

  // Byte clock is far slower than our clock, so edge sampling is exact
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
          sync_c[g] <= 1'b0;
        end else begin
          sync_a[g] <= byte_clk_i[g];
          sync_b[g] <= sync_a[g];
          sync_c[g] <= sync_b[g];
        end
      end
      assign rise[g] = sync_b[g] & ~sync_c[g];
    end
  endgenerate

  assign mask = ~(`LLM_DIV_W'(3'b111 << div_i));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + `LLM_DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else if (src_sel_i) begin
      tick_o <= rise[chan_i];
    end else begin
      tick_o <= (cnt & mask) == mask;
    end
  end

endmodule // llm_tick_gen

// file: logic/llm_latency_meter.sv
// Behaviour
// - Measure only while measure_enable is set
// - measure_channel_select picks channel A or B
// - start_marker_seen marks lanes or half-words with comma
// - stop_marker_seen marks lanes or half-words with comma
// - measure_done latches high when result valid
// - Tally split: bits 19:16 upper, 15:0 lower
// - Tally counts measurement ticks start to stop
// - Tally reads zero before any stop comma
// - Tally saturates at all ones
// - Reading lower register zeroes the tally
// - Reading lower register clears seen and done flags
// - start_point_select: low-speed TX or high-speed RX
// - stop_point_select: low-speed RX or high-speed TX
// - Internal tick divided by 1, 2, 4, 8
// - Alternative tick from recovered byte clock
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "llm_defines.svh"

module llm_latency_meter (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // AXI4-Lite write address
  input wire logic [`LLM_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read address
  input wire logic [`LLM_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Comma events from the channel datapaths, same clock
  input wire llm_pkg::llm_comma_t [1:0] CH_COMMA_I,
  // Recovered byte clocks of channels A and B
  input wire logic [1:0] BYTE_CLK_I,
  // Interrupt
  output logic IRQ_O
);

  import llm_pkg::*;

  localparam int TW = `LLM_TALLY_W;

  llm_ctrl_t ctrl;
  llm_state_t state, next_state;
  llm_comma_t sel;
  logic [TW-1:0] tally;
  logic [TW-1:0] view;
  logic [3:0] start_seen, stop_seen;
  logic [3:0] start_vec, stop_vec;
  logic done, tick, start_hit, stop_hit;
  logic [1:0] irq_stat, irq_mask;
  logic [7:0] aw_idx;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic rd_take;
  logic [7:0] rd_idx;
  logic clr_cnt, clr_irq;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [15:0] ctrl_wr;

  // Write channel: address and data are taken independently
  assign wr_fire = !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      aw_idx <= 8'h00;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      S_AXI_AWREADY_O <= 1'b0;
      aw_idx <= S_AXI_AWADDR_I[`LLM_ADDR_W-1:2];
    end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
      S_AXI_AWREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      S_AXI_WREADY_O <= 1'b1;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      S_AXI_WREADY_O <= 1'b0;
      wdata_q <= S_AXI_WDATA_I;
      wstrb_q <= S_AXI_WSTRB_I;
    end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
      S_AXI_WREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `LLM_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID_O <= 1'b1;
      case (aw_idx)
        `LLM_IDX_CTRL, `LLM_IDX_UPPER, `LLM_IDX_LOWER,
        `LLM_IDX_IRQ_STAT, `LLM_IDX_IRQ_MASK: begin
          S_AXI_BRESP_O <= `LLM_RESP_OKAY;
        end
        default: begin
          S_AXI_BRESP_O <= `LLM_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // Byte lanes 0 and 1 carry the 16-bit register; bit 3 is not writable
  always_comb begin
    ctrl_wr = ctrl;
    if (wstrb_q[0]) begin
      ctrl_wr[7:0] = wdata_q[7:0];
    end
    if (wstrb_q[1]) begin
      ctrl_wr[15:8] = wdata_q[15:8];
    end
    ctrl_wr = ctrl_wr & `LLM_CTRL_WMASK;
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      ctrl <= `LLM_CTRL_RST;
    end else if (wr_fire && aw_idx == `LLM_IDX_CTRL) begin
      ctrl <= ctrl_wr;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      irq_mask <= `LLM_IRQ_MASK_RST;
    end else if (wr_fire && aw_idx == `LLM_IDX_IRQ_MASK && wstrb_q[0]) begin
      irq_mask <= wdata_q[1:0];
    end
  end

  // Read channel: one-cycle answer after the address is taken
  assign rd_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign rd_idx = S_AXI_ARADDR_I[`LLM_ADDR_W-1:2];
  assign clr_cnt = rd_take && rd_idx == `LLM_IDX_LOWER;
  assign clr_irq = rd_take && rd_idx == `LLM_IDX_IRQ_STAT;

  // Result is hidden until the stop comma has been seen
  assign view = done ? tally : '0;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = `LLM_RESP_OKAY;
    case (rd_idx)
      `LLM_IDX_CTRL: begin
        next_rdata[15:0] = ctrl;
      end
      `LLM_IDX_UPPER: begin
        next_rdata[`LLM_UP_START_LSB +: 4] = start_seen;
        next_rdata[`LLM_UP_STOP_LSB +: 4] = stop_seen;
        next_rdata[`LLM_UP_DONE_BIT] = done;
        next_rdata[3:0] = view[TW-1:16];
      end
      `LLM_IDX_LOWER: begin
        next_rdata[15:0] = view[15:0];
      end
      `LLM_IDX_IRQ_STAT: begin
        next_rdata[1:0] = irq_stat;
      end
      `LLM_IDX_IRQ_MASK: begin
        next_rdata[1:0] = irq_mask;
      end
      default: begin
        next_rresp = `LLM_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= `LLM_RESP_OKAY;
    end else if (rd_take) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= next_rdata;
      S_AXI_RRESP_O <= next_rresp;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  llm_tick_gen #(
    .CHANNELS(2)
  ) u_tick (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .src_sel_i(ctrl.tick_src),
    .div_i(ctrl.tick_div),
    .chan_i(ctrl.chan),
    .byte_clk_i(BYTE_CLK_I),
    .tick_o(tick)
  );

  // Comma sources for the chosen channel and points
  assign sel = CH_COMMA_I[ctrl.chan];
  assign start_vec = ctrl.start_sel ? {2'b00, sel.hs_rx} : sel.ls_tx;
  assign stop_vec = ctrl.stop_sel ? {2'b00, sel.hs_tx} : sel.ls_rx;
  assign start_hit = state == ST_ARMED && |start_vec;
  assign stop_hit = state == ST_COUNT && |stop_vec;

  // A stop comma in the clearing cycle wins over the read
  always_comb begin
    next_state = state;
    if (!ctrl.enable) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_state = ST_ARMED;
        end
        ST_ARMED: begin
          if (start_hit) begin
            next_state = ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (stop_hit) begin
            next_state = ST_DONE;
          end else if (clr_cnt) begin
            next_state = ST_ARMED;
          end
        end
        ST_DONE: begin
          if (clr_cnt) begin
            next_state = ST_ARMED;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      tally <= '0;
    end else if (start_hit) begin
      tally <= '0;
    end else if (state == ST_COUNT && !stop_hit && !clr_cnt && tick) begin
      if (tally != `LLM_TALLY_MAX) begin
        tally <= tally + TW'(1);
      end
    end else if (clr_cnt && !stop_hit) begin
      tally <= '0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      start_seen <= 4'h0;
    end else if (start_hit) begin
      start_seen <= start_vec;
    end else if (clr_cnt) begin
      start_seen <= 4'h0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      stop_seen <= 4'h0;
      done <= 1'b0;
    end else if (stop_hit) begin
      stop_seen <= stop_vec;
      done <= 1'b1;
    end else if (clr_cnt) begin
      stop_seen <= 4'h0;
      done <= 1'b0;
    end
  end

  // Events stay set over a clearing read of the same cycle
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat[`LLM_IRQ_START] <= start_hit ||
        (irq_stat[`LLM_IRQ_START] && !clr_irq);
      irq_stat[`LLM_IRQ_DONE] <= stop_hit ||
        (irq_stat[`LLM_IRQ_DONE] && !clr_irq);
    end
  end

  // One cycle behind the status bits, traded for a flopped output
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_stat & irq_mask);
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  a_enable_gate: assert property (
    !ctrl.enable |=> state == ST_IDLE && !start_hit)
    else $error("measurement active while disabled");
  a_done_latch: assert property (
    done && !clr_cnt |=> done)
    else $error("done flag dropped without clearing read");
  a_tally_sat: assert property (
    tally == `LLM_TALLY_MAX && state == ST_COUNT && !clr_cnt
    |=> tally == `LLM_TALLY_MAX)
    else $error("tally wrapped past all ones");
  a_count_step: assert property (
    state == ST_COUNT && tick && !stop_hit && !clr_cnt
    && tally != `LLM_TALLY_MAX |=> tally == $past(tally) + TW'(1))
    else $error("tally missed a measurement tick");
  a_count_hold: assert property (
    state == ST_COUNT && !tick && !clr_cnt |=> tally == $past(tally))
    else $error("tally moved without a tick");
  a_read_clear: assert property (
    clr_cnt && !stop_hit |=> tally == '0 && !done)
    else $error("lower register read did not zero the tally");
  a_flags_clear: assert property (
    clr_cnt && !stop_hit && !start_hit
    |=> stop_seen == 4'h0 && start_seen == 4'h0 && !done)
    else $error("flags survived the clearing read");
  a_hs_unused: assert property (
    start_hit && ctrl.start_sel |=> start_seen[3:2] == 2'b00)
    else $error("unused start bits set in high-speed mode");
  a_read_zero: assert property (
    rd_take && rd_idx == `LLM_IDX_LOWER && !done
    |=> S_AXI_RVALID_O && S_AXI_RDATA_O == 32'h0000_0000)
    else $error("nonzero tally read before stop comma");
  a_irq_level: assert property (
    |(irq_stat & irq_mask) |=> IRQ_O)
    else $error("interrupt not raised for unmasked event");
  a_write_resp: assert property (
    wr_fire |=> S_AXI_BVALID_O [*1] ##0 !S_AXI_AWREADY_O)
    else $error("write response missing after both beats");

endmodule // llm_latency_meter

// file: test/llm_latency_meter_bench.sv
`timescale 1ns/1ps
`include "llm_defines.svh"

module llm_latency_meter_bench;
  import llm_pkg::*;
  localparam logic [9:0] A_CTRL = {`LLM_IDX_CTRL, 2'h0};
  localparam logic [9:0] A_UP = {`LLM_IDX_UPPER, 2'h0};
  localparam logic [9:0] A_LO = {`LLM_IDX_LOWER, 2'h0};
  localparam logic [9:0] A_STAT = {`LLM_IDX_IRQ_STAT, 2'h0};
  localparam logic [9:0] A_MASK = {`LLM_IDX_IRQ_MASK, 2'h0};
  logic clk, rst;
  logic [`LLM_ADDR_W-1:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, bclk;
  llm_comma_t [1:0] comma;
  logic bclk_run;
  logic [2:0] bcnt;
  int fails, comparisons, seed;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];

  llm_latency_meter llm_latency_meter_i (
    .CLOCK_I(clk), .SYS_RST_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .CH_COMMA_I(comma),
    .BYTE_CLK_I(bclk), .IRQ_O(irq)
  );

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Byte clock period of 8 cycles keeps both phases above the sync minimum
  always @(posedge clk) begin
    if (rst) begin
      bcnt <= 3'h0;
      bclk <= 2'h0;
    end else begin
      bcnt <= bcnt + 3'h1;
      bclk <= {2{bclk_run & bcnt[2]}};
    end
  end

  task automatic chk(input string name, input logic [33:0] e, g);
    comparisons++;
    if (e !== g) begin
      fails++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  // Results are compared as they appear, against the oldest note
  always @(posedge clk) begin
    if (rvalid && rready) chk("read", exp_r.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", {32'h0, exp_b.pop_front()}, {32'h0, bresp});
  end

  task automatic wr(input logic [9:0] a, input logic [15:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw, w, b;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h1;
    exp_b.push_back(er);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (aw || w || b) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'h0;
        awvalid <= 1'h0;
      end
      if (w && wready) begin
        w = 1'h0;
        wvalid <= 1'h0;
      end
      if (bvalid) begin
        b = 1'h0;
        bready <= 1'h0;
      end
    end
    // An idle edge, so a next call never re-raises bready in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] e,
                    input logic [1:0] er);
    logic ar, r;
    ar = 1'h1;
    r = 1'h1;
    exp_r.push_back({er, 16'h0000, e});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (ar || r) begin
      @(posedge clk);
      if (ar && arready) begin
        ar = 1'h0;
        arvalid <= 1'h0;
      end
      if (rvalid) begin
        r = 1'h0;
        rready <= 1'h0;
      end
    end
    // An idle edge, so a next call never re-raises rready in this step
    @(posedge clk);
  endtask

  // One-cycle comma on a channel, random noise on the other one
  task automatic pulse(input int ch, input logic [11:0] v);
    llm_comma_t [1:0] c;
    @(posedge clk);
    c[ch] = v;
    c[1-ch] = 12'($random(seed));
    comma <= c;
    @(posedge clk);
    comma <= '0;
  endtask

  task automatic meas(input int hs, input logic [1:0] dv, input logic src,
                      input int gap, input logic [19:0] t);
    logic [3:0] sv, pv;
    int ch;
    ch = $random(seed) & 1;
    sv = 4'($random(seed)) | 4'h1;
    pv = 4'($random(seed)) | 4'h2;
    if (hs != 0) begin
      sv[3:2] = 2'h0;
      pv[3:2] = 2'h0;
    end
    wr(A_CTRL, {8'h7F, hs[0], hs[0], dv, 1'h0, src, 1'h1, ch[0]}, 4'hF, 2'h0);
    pulse(ch, hs != 0 ? {4'h0, sv[1:0], 6'h0} : {sv, 8'h0});
    repeat (gap - 2) @(posedge clk);
    pulse(ch, hs != 0 ? {10'h0, pv[1:0]} : {6'h0, pv, 2'h0});
    pulse(ch, 12'hFFF);
    rd(A_UP, {sv, pv, 3'h0, 1'h1, t[19:16]}, 2'h0);
    rd(A_LO, t[15:0], 2'h0);
    rd(A_UP, 16'h0000, 2'h0);
  endtask

  task complete_run;
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end

  initial begin
    seed = 32'hE27404AD;
    rst = 1'h1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, bclk_run} = '0;
    comma = '0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    rd(A_CTRL, 16'h7F00, 2'h0);
    rd(A_UP, 16'h0000, 2'h0);
    rd(A_LO, 16'h0000, 2'h0);
    rd(A_MASK, 16'h0000, 2'h0);
    rd(10'h3FC, 16'h0000, 2'h2);
    wr(10'h3FC, 16'hFFFF, 4'hF, 2'h2);
    wr(A_UP, 16'hFFFF, 4'hF, 2'h0);
    rd(A_UP, 16'h0000, 2'h0);
    wr(A_CTRL, 16'hFFFF, 4'hF, 2'h0);
    rd(A_CTRL, 16'hFFF7, 2'h0);
    wr(A_CTRL, 16'h0000, 4'h1, 2'h0);
    rd(A_CTRL, 16'hFF00, 2'h0);
    // Disabled: commas must leave no trace
    pulse(0, 12'hFFF);
    pulse(1, 12'hFFF);
    rd(A_UP, 16'h0000, 2'h0);
    for (int i = 0; i < 8; i++) begin
      meas(i / 4, 2'(i), 1'h0, 9, 20'd8 >> (i % 4));
    end
    bclk_run <= 1'h1;
    meas(0, 2'h0, 1'h1, 17, 20'd2);
    @(posedge clk);
    chk("irq", 34'h0, {33'h0, irq});
    wr(A_MASK, 16'h0003, 4'hF, 2'h0);
    repeat (3) @(posedge clk);
    chk("irq", 34'h1, {33'h0, irq});
    rd(A_STAT, 16'h0003, 2'h0);
    repeat (3) @(posedge clk);
    chk("irq", 34'h0, {33'h0, irq});
    // Lower read in mid-count aborts; a late stop is then ignored
    wr(A_CTRL, 16'h7F02, 4'hF, 2'h0);
    pulse(0, 12'h100);
    repeat (3) @(posedge clk);
    rd(A_LO, 16'h0000, 2'h0);
    pulse(0, 12'h004);
    rd(A_UP, 16'h0000, 2'h0);
    complete_run();
  end
endmodule // llm_latency_meter_bench
